// File: pkg/oes_pkg.sv
// package for the otg event status and enable block
// assumes a 100 MHz register clock and an axi4-lite register bus
package oes_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [31:0] OES_ADDR_STATUS_CONTROL = 32'h1900_01a4;
   localparam logic [31:0] OES_ADDR_MODE_CTRL = 32'h1900_01a8;
   localparam logic [31:0] OES_ADDR_MASK = 32'h0000_0ffc;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int OES_BIT_ID = 16;
   localparam int OES_BIT_AVV = 17;
   localparam int OES_BIT_ASV = 18;
   localparam int OES_BIT_BSV = 19;
   localparam int OES_BIT_BSE = 20;
   localparam int OES_BIT_MS = 21;
   localparam int OES_BIT_DP = 22;
   localparam int OES_FLAG_LSB = 16;
   localparam int OES_ENABLE_LSB = 24;
   localparam int OES_NUM_EVENTS = 7;
   localparam int OES_MODE_LSB = 0;
   localparam int OES_POWER_BIT = 2;
   localparam logic [1:0] OES_MODE_HOST = 2'h3;
   localparam logic [1:0] OES_MODE_IDLE = 2'h0;
   localparam logic [6:0] OES_EVENTS_RESET = 7'h00;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int OES_CLK_MHZ = 100;
   localparam int OES_TICK_US = 1000;
   localparam int OES_TICK_CYCLES = OES_TICK_US * OES_CLK_MHZ;
   // ----------------------------------------
   // axi responses
   // ----------------------------------------
   localparam logic [1:0] OES_RESP_OKAY = 2'h0;
   localparam logic [1:0] OES_RESP_SLVERR = 2'h2;
endpackage

// File: hdl/oes_otg_events.sv
// otg event flags with enables behind an axi4-lite slave
// assumes comparator, id and line inputs are static levels from the port
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
// Overview of operation
// - Any rise or fall of the a-vbus valid comparator sets its flag.
// - Any rise or fall of the a-session valid comparator sets its flag.
// - Any rise or fall of the b-session valid comparator sets its flag.
// - Only a fall below the b-session end threshold sets its flag.
// - The millisecond flag is set once in every millisecond period.
// - Pulsing on either data line sets the data pulse flag.
// - Pulsing counts only in host mode with port power off.
// - Writing one clears a flag, writing zero leaves it.
// - A read-write enable bit gates the id change interrupt.
// - Four read-write enable bits gate the vbus threshold interrupts.
// - A read-write enable bit gates the millisecond interrupt.
// - A read-write enable bit gates the data pulse interrupt.
// - Any change of the sampled id level sets the id change flag.
module oes_otg_events
   import oes_pkg::*;
#(
   parameter int TICK_CYCLES = OES_TICK_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // axi4-lite write
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // port sensing
   input wire logic idPin,
   input wire logic aVbusValid,
   input wire logic aSessionValid,
   input wire logic bSessionValid,
   input wire logic bSessionEnd,
   input wire logic dpPulse,
   input wire logic dmPulse,
   // interrupt
   output logic irq
);
   // ----------------------------------------
   // synchronisers
   // ----------------------------------------
   logic [6:0] syncA;
   logic [6:0] syncB;
   logic [6:0] syncPrev;
   logic [6:0] flags;
   logic [6:0] enables;
   logic [6:0] setEv;
   logic [6:0] clrEv;
   logic [1:0] controllerMode;
   logic port_power_control;
   logic [31:0] tickCount;
   logic tick;
   logic pulseAllowed;
   logic [31:0] awAddrHeld;
   logic [31:0] wDataHeld;
   logic [3:0] wStrbHeld;
   logic awHave;
   logic wHave;
   logic doWrite;

   // three flops per input; only syncB and syncPrev are looked at downstream
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         syncA <= 7'h00;
         syncB <= 7'h00;
         syncPrev <= 7'h00;
      end else begin
         syncA <= {dmPulse, dpPulse, bSessionEnd, bSessionValid, aSessionValid,
                   aVbusValid, idPin};
         syncB <= syncA;
         syncPrev <= syncB;
      end
   end

   // ----------------------------------------
   // millisecond divider
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tickCount <= 32'h0000_0000;
         tick <= 1'b0;
      end else if (tickCount == 32'(TICK_CYCLES - 1)) begin
         tickCount <= 32'h0000_0000;
         tick <= 1'b1;
      end else begin
         tickCount <= tickCount + 32'h0000_0001;
         tick <= 1'b0;
      end
   end

   // ----------------------------------------
   // event detection
   // ----------------------------------------
   // pulsing is an sr probe only meaningful as an unpowered host
   assign pulseAllowed = (controllerMode == OES_MODE_HOST) && !port_power_control;
   always_comb begin
      setEv = 7'h00;
      setEv[OES_BIT_ID - OES_FLAG_LSB] = syncB[0] ^ syncPrev[0];
      setEv[OES_BIT_AVV - OES_FLAG_LSB] = syncB[1] ^ syncPrev[1];
      setEv[OES_BIT_ASV - OES_FLAG_LSB] = syncB[2] ^ syncPrev[2];
      setEv[OES_BIT_BSV - OES_FLAG_LSB] = syncB[3] ^ syncPrev[3];
      // end indicator rises when vbus falls below the threshold
      setEv[OES_BIT_BSE - OES_FLAG_LSB] = syncB[4] & ~syncPrev[4];
      setEv[OES_BIT_MS - OES_FLAG_LSB] = tick;
      setEv[OES_BIT_DP - OES_FLAG_LSB] = pulseAllowed &
         ((syncB[5] & ~syncPrev[5]) | (syncB[6] & ~syncPrev[6]));
   end

   // ----------------------------------------
   // axi4-lite write channel
   // ----------------------------------------
   assign doWrite = awHave && wHave && !bvalid;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         awHave <= 1'b0;
         wHave <= 1'b0;
         awready <= 1'b1;
         wready <= 1'b1;
         awAddrHeld <= 32'h0000_0000;
         wDataHeld <= 32'h0000_0000;
         wStrbHeld <= 4'h0;
         bvalid <= 1'b0;
         bresp <= OES_RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            awHave <= 1'b1;
            awready <= 1'b0;
            awAddrHeld <= awaddr;
         end
         if (wvalid && wready) begin
            wHave <= 1'b1;
            wready <= 1'b0;
            wDataHeld <= wdata;
            wStrbHeld <= wstrb;
         end
         if (doWrite) begin
            awHave <= 1'b0;
            wHave <= 1'b0;
            bvalid <= 1'b1;
            bresp <= (awAddrHeld[11:2] == OES_ADDR_STATUS_CONTROL[11:2] ||
                      awAddrHeld[11:2] == OES_ADDR_MODE_CTRL[11:2]) ?
                     OES_RESP_OKAY : OES_RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // flags, enables and mode control
   // ----------------------------------------
   // only the word's upper lanes carry flags and enables
   always_comb begin
      clrEv = 7'h00;
      if (doWrite && awAddrHeld[11:2] == OES_ADDR_STATUS_CONTROL[11:2] && wStrbHeld[2]) begin
         clrEv = wDataHeld[OES_FLAG_LSB +: OES_NUM_EVENTS];
      end
   end

   // set wins over a clear arriving in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flags <= OES_EVENTS_RESET;
      end else begin
         flags <= (flags & ~clrEv) | setEv;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         enables <= OES_EVENTS_RESET;
      end else if (doWrite && awAddrHeld[11:2] == OES_ADDR_STATUS_CONTROL[11:2] &&
                   wStrbHeld[3]) begin
         // bit 31 is reserved and dropped here
         enables <= wDataHeld[OES_ENABLE_LSB +: OES_NUM_EVENTS];
      end
   end

   // stand-in for the mode field and port power, which live elsewhere
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         controllerMode <= OES_MODE_IDLE;
         port_power_control <= 1'b0;
      end else if (doWrite && awAddrHeld[11:2] == OES_ADDR_MODE_CTRL[11:2] && wStrbHeld[0]) begin
         controllerMode <= wDataHeld[OES_MODE_LSB +: 2];
         port_power_control <= wDataHeld[OES_POWER_BIT];
      end
   end

   // ----------------------------------------
   // interrupt
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(flags & enables);
      end
   end

   // ----------------------------------------
   // axi4-lite read channel
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= OES_RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= OES_RESP_OKAY;
         if (araddr[11:2] == OES_ADDR_STATUS_CONTROL[11:2]) begin
            // reserved bits 23 and 31 read zero
            rdata <= {1'b0, enables, 1'b0, flags, 16'h0000};
         end else if (araddr[11:2] == OES_ADDR_MODE_CTRL[11:2]) begin
            rdata <= {29'h0000_0000, port_power_control, controllerMode};
         end else begin
            rdata <= 32'h0000_0000;
            rresp <= OES_RESP_SLVERR;
         end
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_bse_fall_only: assert property (@(posedge clk) disable iff (rst)
      (!syncPrev[4] && syncB[4] && !flags[4]) |=> flags[4])
      else $error("session end fall not flagged");
   a_bse_no_rise: assert property (@(posedge clk) disable iff (rst)
      (syncPrev[4] && !syncB[4] && !flags[4] && !tick) |=> !flags[4])
      else $error("session end flagged on rise");
   a_avv_edge_set: assert property (@(posedge clk) disable iff (rst)
      $changed(syncB[1]) |=> flags[1])
      else $error("a-vbus edge not flagged");
   a_asv_edge_set: assert property (@(posedge clk) disable iff (rst)
      $changed(syncB[2]) |=> flags[2])
      else $error("a-session edge not flagged");
   a_bsv_edge_set: assert property (@(posedge clk) disable iff (rst)
      $changed(syncB[3]) |=> flags[3])
      else $error("b-session edge not flagged");
   a_id_edge_set: assert property (@(posedge clk) disable iff (rst)
      $changed(syncB[0]) |=> flags[0])
      else $error("id change not flagged");
   a_tick_sets_flag: assert property (@(posedge clk) disable iff (rst)
      tick |=> flags[5] ##1 !tick)
      else $error("millisecond flag not set");
   a_pulse_gated: assert property (@(posedge clk) disable iff (rst)
      (!pulseAllowed && !flags[6]) |=> !flags[6])
      else $error("pulse flagged outside host unpowered");
   a_clear_works: assert property (@(posedge clk) disable iff (rst)
      (clrEv[0] && !setEv[0]) |=> !flags[0])
      else $error("write one did not clear");
   a_irq_follows: assert property (@(posedge clk) disable iff (rst)
      ##1 irq == |($past(flags) & $past(enables)))
      else $error("interrupt does not follow flags");
   c_write_done: cover property (@(posedge clk) disable iff (rst) bvalid && bready);
   c_irq_rise: cover property (@(posedge clk) disable iff (rst) $rose(irq));
   c_set_and_clear: cover property (@(posedge clk) disable iff (rst) |(setEv & clrEv));
   c_pulse_seen: cover property (@(posedge clk) disable iff (rst) setEv[6]);
endmodule

// File: sim/oes_port_model.sv
// port-side model: vbus comparators, id sensing and data-line pulsing
// assumes the bench sets target levels by non-blocking assignment at clk
`timescale 1ns/10ps
module oes_port_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // target levels {dm, dp, bse, bsv, asv, avv, id}
   input wire logic [6:0] lvl,
   // sensed lines
   output logic idPin,
   output logic aVbusValid,
   output logic aSessionValid,
   output logic bSessionValid,
   output logic bSessionEnd,
   output logic dpPulse,
   output logic dmPulse
);
   logic [6:0] hold;
   // comparators settle a clock late, so the block never sees a change on its own edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold <= 7'h00;
      end else begin
         hold <= lvl;
      end
   end
   // bse is high while vbus is below the session end threshold
   assign {dmPulse, dpPulse, bSessionEnd, bSessionValid, aSessionValid, aVbusValid, idPin} = hold;
endmodule

// File: sim/tb_top.sv
// self-checking bench for the otg event flags and enables
// assumes the port model on the sensing inputs and axi4-lite driven from here
`timescale 1ns/10ps
module tb_top;
   import oes_pkg::*;
   logic clk, awready, wready, bvalid, arready, rvalid, irq;
   logic rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, seed, rv, en;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] bresp, rresp, resp;
   logic [6:0] lvl = 7'h00, nl, expF = 7'h00;
   logic idPin, aVbusValid, aSessionValid, bSessionValid, bSessionEnd, dpPulse, dmPulse;
   int mismatches = 0;
   int nCompared = 0;
   // the millisecond flag runs free, so it is left out of whole-word compares
   localparam logic [31:0] MSK = 32'hffdf_ffff;
   localparam logic [31:0] ST = OES_ADDR_STATUS_CONTROL;

   oes_otg_events #(.TICK_CYCLES(10)) i_dut (.clk, .rst, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .idPin, .aVbusValid, .aSessionValid, .bSessionValid,
      .bSessionEnd, .dpPulse, .dmPulse, .irq);
   oes_port_model i_port (.clk, .rst, .lvl, .idPin, .aVbusValid, .aSessionValid,
      .bSessionValid, .bSessionEnd, .dpPulse, .dmPulse);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nCompared++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // ready is stable from negedge to posedge, so it is sampled there
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      logic ha, hw, hb;
      // one edge between calls, so a strobe is never lowered and raised in one step
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge clk);
         ha = awvalid && awready;
         hw = wvalid && wready;
         hb = bvalid;
         resp = bresp;
         @(posedge clk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         if (hb) bready <= 1'b0;
      end while (!hb);
   endtask
   task automatic rd(input logic [31:0] a);
      logic ha, hr;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge clk);
         ha = arvalid && arready;
         hr = rvalid;
         rv = rdata;
         resp = rresp;
         @(posedge clk);
         if (ha) arvalid <= 1'b0;
         if (hr) rready <= 1'b0;
      end while (!hr);
   endtask
   task automatic end_of_test;
      if (mismatches == 0 && nCompared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // watchdog: the run needs about 1000 cycles
   initial begin
      #300000;
      mismatches++;
      end_of_test;
   end
   // main sequence: reset, random line changes per mode, tick, unmapped access
   initial begin
      seed = 32'h0000_8568;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(ST);
      chk(rv & MSK, 32'h0000_0000);
      chk({30'h0, resp}, {30'h0, OES_RESP_OKAY});
      chk({31'h0, irq}, 32'h0000_0000);
      for (int i = 0; i < 32; i++) begin
         seed = xs(seed);
         wr(OES_ADDR_MODE_CTRL, {29'h0, i[2:0]});
         rd(OES_ADDR_MODE_CTRL);
         chk(rv, {29'h0, i[2:0]});
         nl = lvl ^ seed[6:0];
         lvl <= nl;
         en = {1'b0, seed[14:8] & 7'h5f, 24'h0};
         expF[3:0] = expF[3:0] | (nl[3:0] ^ lvl[3:0]);
         expF[4] = expF[4] | (nl[4] & !lvl[4]);
         expF[6] = expF[6] | ((i[2:0] == 3'h3) && |(nl[6:5] & ~lvl[6:5]));
         repeat (8) @(posedge clk);
         // flags written as zero, reserved bits carry noise
         wr(ST, en | (seed & 32'h8080_ffff));
         chk({30'h0, resp}, {30'h0, OES_RESP_OKAY});
         rd(ST);
         chk(rv & MSK, en | {9'h0, expF, 16'h0});
         chk({31'h0, irq}, {31'h0, |(expF & en[30:24])});
         wr(ST, en | 32'h007f_0000);
         expF = 7'h00;
         rd(ST);
         chk(rv & MSK, en);
         chk({31'h0, irq}, 32'h0000_0000);
      end
      // byte lanes: the enable lane alone keeps flags, the flag lane alone keeps enables
      lvl <= lvl ^ 7'h01;
      repeat (8) @(posedge clk);
      wstrb <= 4'h8;
      wr(ST, 32'h0101_0000);
      rd(ST);
      chk(rv & 32'h0101_0000, 32'h0101_0000);
      chk({31'h0, irq}, 32'h0000_0001);
      wstrb <= 4'h4;
      wr(ST, 32'h0001_0000);
      rd(ST);
      chk(rv & 32'h0101_0000, 32'h0100_0000);
      chk({31'h0, irq}, 32'h0000_0000);
      wstrb <= 4'hf;
      wr(ST, 32'h2000_0000);
      repeat (15) @(posedge clk);
      rd(ST);
      chk(rv & 32'h0020_0000, 32'h0020_0000);
      chk({31'h0, irq}, 32'h0000_0001);
      wr(ST, 32'h0020_0000);
      // irq is relaunched on the edge that ends the write, so look once it has settled
      @(negedge clk);
      chk({31'h0, irq}, 32'h0000_0000);
      wr(32'h1900_0100, 32'hffff_ffff);
      chk({30'h0, resp}, {30'h0, OES_RESP_SLVERR});
      rd(32'h1900_0100);
      chk({30'h0, resp}, {30'h0, OES_RESP_SLVERR});
      chk(rv, 32'h0000_0000);
      rd(ST);
      chk(rv & 32'hff00_0000, 32'h0000_0000);
      end_of_test;
   end
endmodule
